// ---- hdl/ihbp_pkg.sv ----
// package of constants for the isa host bus port
package ihbp_pkg;
    localparam int          DATA_W         = 8;
    localparam int          ADDR_W         = 3;
    localparam int          NUM_DMA_CH     = 3;
    localparam int          NUM_IRQ        = 3;
    localparam logic [10:0] UPPER_BANK_OFS = 11'h400;
    localparam int          UPPER_BANK_BIT = 10;
    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          IRQ_PULSE_NS   = 100;
    localparam int          IRQ_PULSE_CYC  = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          WAIT_NS        = 60;
    localparam int          WAIT_CYC       = (WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  DMA_CH1        = 2'h0;
    localparam logic [1:0]  DMA_CH2        = 2'h1;
    localparam logic [1:0]  DMA_CH3        = 2'h2;
    localparam logic [1:0]  IRQ_SEL5       = 2'h0;
    localparam logic [1:0]  IRQ_SEL7       = 2'h1;
    localparam logic [1:0]  IRQ_SEL9       = 2'h2;
    localparam logic [7:0]  RESET_DATA     = 8'h00;
    typedef enum logic [1:0] {
        IHBP_DMA_IDLE = 2'b00,
        IHBP_DMA_REQ  = 2'b01,
        IHBP_DMA_ACK  = 2'b10,
        IHBP_DMA_DONE = 2'b11
    } ihbp_dma_state_t;
endpackage : ihbp_pkg

// ---- hdl/ihbp_sync.sv ----
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
`default_nettype none
module ihbp_sync #(
    parameter int           WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1   <= INIT;
            sync_out <= INIT;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // ihbp_sync
`default_nettype wire

// ---- hdl/ihbp_top.sv ----
// isa host bus port: decode, strobes, wait, interrupts and dma handshake
// Function
// - address bit 10 set selects the upper bank, 0x400 above base
// - register transfers only while chip select is low
// - channel ready pulled low while extra cycles needed, else released
// - read strobe active low; data bus driven only during selected read or dma read cycle
// - interrupt drives selected line low; other lines stay released
// - dma request raises the chosen channel's request line high
// - a raised request stays high until its acknowledge goes low
// - request outputs exist for channels 3, 2 and 1, three-state
// - terminal count high pulse ends the dma operation and requests
// - upper bank events interrupt as low pulses; legacy interrupt is level
// - accesses with address bit 10 set are accepted
// - dma channel selectable 1, 2 or 3; interrupt line 5, 7 or 9
`timescale 1ns/1ns
`default_nettype none
module ihbp_top #(
    parameter int WAIT_CYCLES = ihbp_pkg::WAIT_CYC,
    parameter int PULSE_CYCLES = ihbp_pkg::IRQ_PULSE_CYC
) (
    input  wire logic                       ref_clk_in,
    input  wire logic                       rst_in,
    // isa pins
    input  wire logic                       addr_hi_in,
    input  wire logic [ihbp_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [ihbp_pkg::DATA_W-1:0] data_in,
    output var  logic [ihbp_pkg::DATA_W-1:0] data_out,
    output logic                            data_oe_out,
    input  wire logic                       cs_n_in,
    input  wire logic                       ior_n_in,
    input  wire logic                       iow_n_in,
    input  wire logic                       aen_in,
    input  wire logic                       tc_in,
    output logic                            iochrdy_out,
    output logic                            iochrdy_oe_out,
    output logic [ihbp_pkg::NUM_IRQ-1:0]    irq_n_out,
    output logic [ihbp_pkg::NUM_IRQ-1:0]    irq_oe_out,
    output logic [ihbp_pkg::NUM_DMA_CH-1:0] drq_out,
    output logic [ihbp_pkg::NUM_DMA_CH-1:0] drq_oe_out,
    input  wire logic [ihbp_pkg::NUM_DMA_CH-1:0] dack_n_in,
    // configuration straps
    input  wire logic [1:0]                 dma_sel_in,
    input  wire logic [1:0]                 irq_sel_in,
    input  wire logic                       dma_enable_in,
    // internal register file side
    output var  logic                       reg_wr_out,
    output logic                            reg_rd_out,
    output var  logic                       reg_upper_out,
    output var  logic [ihbp_pkg::ADDR_W-1:0] reg_addr_out,
    output var  logic [ihbp_pkg::DATA_W-1:0] reg_wdata_out,
    input  wire logic [ihbp_pkg::DATA_W-1:0] reg_rdata_in,
    input  wire logic                       reg_busy_in,
    output var  logic                       dma_wr_out,
    output logic                            dma_rd_out,
    output var  logic                       dma_tc_out,
    input  wire logic                       dma_req_in,
    input  wire logic                       legacy_irq_in,
    input  wire logic                       ext_irq_event_in
);
    if (WAIT_CYCLES < 1 || WAIT_CYCLES > 255) begin : g_bad_wait
        $error("WAIT_CYCLES out of range");
    end
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) begin : g_bad_pulse
        $error("PULSE_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int SW = 6 + ihbp_pkg::NUM_DMA_CH + ihbp_pkg::ADDR_W + ihbp_pkg::DATA_W;
    logic [SW-1:0] raw_pins;
    logic [SW-1:0] sync_pins;
    assign raw_pins = {cs_n_in, ior_n_in, iow_n_in, aen_in, tc_in, addr_hi_in,
                       dack_n_in, addr_in, data_in};

    ihbp_sync #(
        .WIDTH (SW),
        .INIT  ({4'hE, 2'h0, {ihbp_pkg::NUM_DMA_CH{1'b1}},
                 {(ihbp_pkg::ADDR_W + ihbp_pkg::DATA_W){1'b0}}})
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .async_in   (raw_pins),
        .sync_out   (sync_pins)
    );

    wire logic                           s_cs_n  = sync_pins[SW-1];
    wire logic                           s_ior_n = sync_pins[SW-2];
    wire logic                           s_iow_n = sync_pins[SW-3];
    wire logic                           s_aen   = sync_pins[SW-4];
    wire logic                           s_tc    = sync_pins[SW-5];
    wire logic                           s_ahi   = sync_pins[SW-6];
    wire logic [ihbp_pkg::NUM_DMA_CH-1:0] s_dack_n =
        sync_pins[ihbp_pkg::ADDR_W+ihbp_pkg::DATA_W +: ihbp_pkg::NUM_DMA_CH];
    wire logic [ihbp_pkg::ADDR_W-1:0]    s_addr  = sync_pins[ihbp_pkg::DATA_W +: ihbp_pkg::ADDR_W];
    wire logic [ihbp_pkg::DATA_W-1:0]    s_data  = sync_pins[ihbp_pkg::DATA_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // processor cycle decode
    logic iow_n_d;
    logic ior_n_d;
    logic [7:0] wait_cnt;
    wire logic cpu_sel   = ~s_cs_n & ~s_aen;
    wire logic rd_active = cpu_sel & ~s_ior_n;
    wire logic wr_rise   = cpu_sel & s_iow_n & ~iow_n_d;
    wire logic rd_start  = rd_active & ior_n_d;
    wire logic dack_any  = ~(&s_dack_n);
    wire logic dma_cycle = s_aen & dack_any;
    wire logic wr_start  = cpu_sel & ~s_iow_n & iow_n_d;

    assign reg_rd_out  = rd_start;
    assign dma_rd_out  = dma_cycle & ~s_ior_n & ior_n_d;
    assign data_oe_out = rd_active | (dma_cycle & ~s_ior_n);
    assign iochrdy_out    = 1'b0;
    assign iochrdy_oe_out = (wait_cnt != 8'h00) | ((rd_active | ~s_iow_n & cpu_sel) & reg_busy_in);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            iow_n_d       <= 1'b1;
            ior_n_d       <= 1'b1;
            reg_wr_out    <= 1'b0;
            dma_wr_out    <= 1'b0;
            reg_upper_out <= 1'b0;
            reg_addr_out  <= '0;
            reg_wdata_out <= ihbp_pkg::RESET_DATA;
            data_out      <= ihbp_pkg::RESET_DATA;
            wait_cnt      <= 8'h00;
        end else begin
            iow_n_d    <= s_iow_n;
            ior_n_d    <= s_ior_n;
            reg_wr_out <= wr_rise;
            dma_wr_out <= dma_cycle & s_iow_n & ~iow_n_d;
            if (wr_rise | rd_start) begin
                reg_upper_out <= s_ahi;
                reg_addr_out  <= s_addr;
            end
            if (~s_iow_n) begin
                reg_wdata_out <= s_data;
            end
            if (data_oe_out) begin
                data_out <= reg_rdata_in;
            end
            if (rd_start | wr_start) begin
                wait_cnt <= 8'(WAIT_CYCLES);
            end else if (wait_cnt != 8'h00) begin
                wait_cnt <= wait_cnt - 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dma request handshake
    ihbp_pkg::ihbp_dma_state_t dma_state;
    ihbp_pkg::ihbp_dma_state_t next_dma_state;
    logic [1:0] dma_ch;
    wire logic ch_valid = (dma_ch == ihbp_pkg::DMA_CH1) | (dma_ch == ihbp_pkg::DMA_CH2)
                        | (dma_ch == ihbp_pkg::DMA_CH3);
    wire logic ch_ack   = ch_valid & ~s_dack_n[dma_ch];
    wire logic tc_hit   = s_tc & ch_ack & s_aen;

    always_comb begin
        next_dma_state = dma_state;
        unique case (dma_state)
            ihbp_pkg::IHBP_DMA_IDLE: begin
                if (dma_enable_in & dma_req_in & ch_valid) begin
                    next_dma_state = ihbp_pkg::IHBP_DMA_REQ;
                end
            end
            ihbp_pkg::IHBP_DMA_REQ: begin
                if (tc_hit) begin
                    next_dma_state = ihbp_pkg::IHBP_DMA_DONE;
                end else if (ch_ack) begin
                    next_dma_state = ihbp_pkg::IHBP_DMA_ACK;
                end
            end
            ihbp_pkg::IHBP_DMA_ACK: begin
                if (tc_hit) begin
                    next_dma_state = ihbp_pkg::IHBP_DMA_DONE;
                end else if (~ch_ack) begin
                    next_dma_state = ihbp_pkg::IHBP_DMA_IDLE;
                end
            end
            ihbp_pkg::IHBP_DMA_DONE: begin
                if (~dma_enable_in) begin
                    next_dma_state = ihbp_pkg::IHBP_DMA_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dma_state  <= ihbp_pkg::IHBP_DMA_IDLE;
            dma_ch     <= ihbp_pkg::DMA_CH3;
            dma_tc_out <= 1'b0;
        end else begin
            dma_state  <= next_dma_state;
            dma_tc_out <= tc_hit & ((dma_state == ihbp_pkg::IHBP_DMA_REQ) | (dma_state == ihbp_pkg::IHBP_DMA_ACK));
            if (dma_state == ihbp_pkg::IHBP_DMA_IDLE) begin
                dma_ch <= dma_sel_in;
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < ihbp_pkg::NUM_DMA_CH; ch++) begin : g_drq
            assign drq_out[ch]    = (dma_state == ihbp_pkg::IHBP_DMA_REQ) & (dma_ch == 2'(ch));
            assign drq_oe_out[ch] = dma_enable_in & (dma_ch == 2'(ch));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // interrupt lines
    logic [7:0] pulse_cnt;
    logic [1:0] irq_line;
    wire logic irq_active = legacy_irq_in | (pulse_cnt != 8'h00);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pulse_cnt <= 8'h00;
            irq_line  <= ihbp_pkg::IRQ_SEL7;
        end else begin
            if (~irq_active) begin
                irq_line <= irq_sel_in;
            end
            if (ext_irq_event_in) begin
                pulse_cnt <= 8'(PULSE_CYCLES);
            end else if (pulse_cnt != 8'h00) begin
                pulse_cnt <= pulse_cnt - 8'h01;
            end
        end
    end

    genvar ir;
    generate
        for (ir = 0; ir < ihbp_pkg::NUM_IRQ; ir++) begin : g_irq
            assign irq_n_out[ir]  = 1'b0;
            assign irq_oe_out[ir] = irq_active & (irq_line == 2'(ir));
        end
    endgenerate
endmodule // ihbp_top
`default_nettype wire

// ---- verif/ihbp_dma_model.sv ----
// behavioural system dma controller answering the request lines
`timescale 1ns/1ns
`default_nettype none
module ihbp_dma_model (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    input  wire logic [2:0] drq_in,
    input  wire logic [2:0] drq_oe_in,
    input  wire logic [3:0] ack_dly_in,
    input  wire logic       last_in,
    output var  logic [2:0] dack_n_out,
    output var  logic       aen_out,
    output var  logic       tc_out
);
    logic [2:0] grant;
    initial begin
        dack_n_out = 3'h7;
        aen_out = 1'b0;
        tc_out = 1'b0;
    end
    always begin
        @(negedge ref_clk_in);
        grant = drq_in & drq_oe_in;
        if (!rst_in && grant != 3'h0) begin
            repeat (ack_dly_in) @(negedge ref_clk_in);
            aen_out <= 1'b1;
            dack_n_out <= ~grant;
            tc_out <= last_in;
            @(negedge ref_clk_in);
            tc_out <= 1'b0;
            repeat (4) @(negedge ref_clk_in);
            dack_n_out <= 3'h7;
            aen_out <= 1'b0;
        end
    end
endmodule // ihbp_dma_model
`default_nettype wire

// ---- verif/ihbp_monitor.sv ----
// pin-level checker of the isa host bus port
`timescale 1ns/1ns
`default_nettype none
module ihbp_monitor (
    input wire logic       ref_clk_in,
    input wire logic       rst_in,
    input wire logic       ior_n_in,
    input wire logic       cs_n_in,
    input wire logic       aen_in,
    input wire logic       tc_in,
    input wire logic       data_oe_out,
    input wire logic       iochrdy_oe_out,
    input wire logic       reg_wr_out,
    input wire logic [1:0] irq_sel_in,
    input wire logic [2:0] irq_oe_out,
    input wire logic       legacy_irq_in,
    input wire logic       ext_irq_event_in,
    input wire logic [2:0] drq_out,
    input wire logic [2:0] dack_n_in,
    input wire logic       dma_req_in,
    input wire logic [1:0] dma_sel_in,
    input wire logic       dma_tc_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    chk_rd_drive: assert property (data_oe_out |-> !$past(ior_n_in, 2))
        else $error("data bus driven without read strobe");
    chk_wait_select: assert property (iochrdy_oe_out |-> !$past(cs_n_in, 2) && !$past(aen_in, 2))
        else $error("wait asserted outside a selected cycle");
    chk_wr_select: assert property (reg_wr_out |-> !$past(cs_n_in, 3) && !$past(aen_in, 3))
        else $error("write taken while unselected");
    chk_irq_pulse: assert property (ext_irq_event_in |=> (irq_oe_out == (3'h1 << irq_sel_in)) [*5])
        else $error("event interrupt pulse wrong");
    chk_legacy_level: assert property (legacy_irq_in |-> irq_oe_out == (3'h1 << irq_sel_in))
        else $error("legacy interrupt line wrong");
    chk_drq_hold: assert property (($past(drq_out) & ~drq_out & $past(dack_n_in, 2) & $past(dack_n_in, 3)) == 3'h0)
        else $error("request dropped without acknowledge");
    chk_drq_raise: assert property ($rose(|drq_out) |-> $past(dma_req_in) && drq_out == (3'h1 << dma_sel_in))
        else $error("request raised on wrong channel");
    chk_tc_stop: assert property (dma_tc_out |-> ##1 (drq_out == 3'h0) [*4])
        else $error("request after terminal count");
    chk_tc_source: assert property (dma_tc_out |-> $past(tc_in, 3) && $past(aen_in, 3))
        else $error("terminal count pulse without count input");
    cover property (reg_wr_out);
    cover property (dma_tc_out);
    cover property (ext_irq_event_in ##1 irq_oe_out != 3'h0);
endmodule // ihbp_monitor
bind ihbp_top ihbp_monitor u_ihbp_monitor (.*);
`default_nettype wire

// ---- verif/isa_host_bus_port_tb_top.sv ----
// testbench of the isa host bus port
`timescale 1ns/1ns
`default_nettype none
module isa_host_bus_port_tb_top;
    logic             ref_clk_in, rst_in, addr_hi_in, cs_n_in, ior_n_in, iow_n_in, tb_aen, dma_aen, tc_in;
    logic             data_oe_out, iochrdy_out, iochrdy_oe_out, reg_wr_out, reg_rd_out, reg_upper_out;
    logic             dma_enable_in, dma_req_in, legacy_irq_in, ext_irq_event_in, last_tc;
    logic             dma_wr_out, dma_rd_out, dma_tc_out;
    logic [1:0]       dma_sel_in, irq_sel_in;
    logic [2:0]       addr_in, irq_n_out, irq_oe_out, drq_out, drq_oe_out, dack_n_in, reg_addr_out;
    logic [3:0]       ack_dly;
    logic [7:0]       data_in, data_out, reg_wdata_out;
    wire  logic [7:0] reg_rdata_in = 8'hA5;
    wire  logic       reg_busy_in  = 1'b0;
    wire  logic       aen_in       = tb_aen | dma_aen;
    int               failures     = 0;
    int               num_checks   = 0;
    ihbp_top u_ihbp_top (
        .ref_clk_in, .rst_in, .addr_hi_in, .addr_in, .data_in, .data_out, .data_oe_out, .cs_n_in, .ior_n_in,
        .iow_n_in, .aen_in, .tc_in, .iochrdy_out, .iochrdy_oe_out, .irq_n_out, .irq_oe_out, .drq_out, .drq_oe_out,
        .dack_n_in, .dma_sel_in, .irq_sel_in, .dma_enable_in, .reg_wr_out, .reg_rd_out, .reg_upper_out,
        .reg_addr_out, .reg_wdata_out, .reg_rdata_in, .reg_busy_in, .dma_wr_out, .dma_rd_out, .dma_tc_out,
        .dma_req_in, .legacy_irq_in, .ext_irq_event_in);
    ihbp_dma_model u_ihbp_dma_model (.ref_clk_in, .rst_in, .drq_in(drq_out), .drq_oe_in(drq_oe_out),
        .ack_dly_in(ack_dly), .last_in(last_tc), .dack_n_out(dack_n_in), .aen_out(dma_aen), .tc_out(tc_in));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic io_wr(input logic [2:0] a, input logic hi, input logic [7:0] d, input logic sel_n, en, ok);
        int         waits;
        logic [7:0] got;
        waits = 0;
        got = 8'h00;
        {cs_n_in, tb_aen, addr_in, addr_hi_in, data_in} = {sel_n, en, a, hi, d};
        for (int i = 0; i < 14; i++) begin
            @(negedge ref_clk_in);
            iow_n_in = !(i >= 1 && i < 6);
            waits += int'(iochrdy_oe_out);
            if (reg_wr_out === 1'b1) got = reg_wdata_out;
        end
        {cs_n_in, tb_aen} = 2'h2;
        check(got, ok ? d : 8'h00);
        check(8'(waits), ok ? 8'(ihbp_pkg::WAIT_CYC) : 8'h00);
        check({7'h00, iochrdy_out}, 8'h00);
        if (ok) check({4'h0, reg_upper_out, reg_addr_out}, {4'h0, hi, a});
        @(negedge ref_clk_in);
    endtask
    task automatic io_rd(input logic sel_n, ok);
        int rds;
        rds = 0;
        {cs_n_in, addr_in} = {sel_n, 3'h3};
        for (int i = 0; i < 9; i++) begin
            @(negedge ref_clk_in);
            ior_n_in = !(i >= 1 && i < 7);
            rds += int'(reg_rd_out === 1'b1);
            if (i == 5) check({7'h00, data_oe_out}, {7'h00, ok});
            if (i == 5 && ok) check(data_out, 8'hA5);
        end
        cs_n_in = 1'b1;
        check(8'(rds), {7'h00, ok});
        @(negedge ref_clk_in);
    endtask
    task automatic s_irq();
        int hits;
        for (int s = 0; s < 3; s++) begin
            irq_sel_in = 2'(s);
            hits = 0;
            ext_irq_event_in = 1'b1;
            @(negedge ref_clk_in);
            ext_irq_event_in = 1'b0;
            repeat (10) begin
                hits += int'(irq_oe_out === (3'h1 << s));
                @(negedge ref_clk_in);
            end
            check(8'(hits), 8'(ihbp_pkg::IRQ_PULSE_CYC));
            legacy_irq_in = 1'b1;
            @(negedge ref_clk_in);
            check({5'h00, irq_oe_out}, 8'h01 << s);
            check({5'h00, irq_n_out & irq_oe_out}, 8'h00);
            legacy_irq_in = 1'b0;
            @(negedge ref_clk_in);
            check({5'h00, irq_oe_out}, 8'h00);
        end
    endtask
    task automatic s_dma(input logic [1:0] ch, input logic tc);
        int n;
        int tcs;
        int rds;
        n = 0;
        tcs = 0;
        rds = 0;
        {dma_sel_in, ack_dly, last_tc, dma_enable_in, dma_req_in} = {ch, 4'(2 + 3 * ch), tc, 2'h3};
        while (n < 40 && dack_n_in === 3'h7) begin
            @(negedge ref_clk_in);
            n++;
        end
        @(negedge ref_clk_in);
        check({5'h00, drq_out & drq_oe_out}, 8'h01 << ch);
        ior_n_in = 1'b0;
        for (int i = 0; i < 3; i++) begin
            @(negedge ref_clk_in);
            if (i == 2) ior_n_in = 1'b1;
            tcs += int'(dma_tc_out === 1'b1);
            rds += int'(dma_rd_out === 1'b1);
        end
        check({5'h00, drq_out}, 8'h00);
        check(8'(tcs), {7'h00, tc});
        check(8'(rds), 8'h01);
        if (tc) begin
            repeat (12) @(negedge ref_clk_in);
            check({5'h00, drq_out}, 8'h00);
        end
        {dma_req_in, dma_enable_in} = 2'h0;
        repeat (14) @(negedge ref_clk_in);
        check({5'h00, drq_oe_out}, 8'h00);
    endtask
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        #200000;
        failures++;
        final_report();
    end
    initial begin
        rst_in = 1'b1;
        {cs_n_in, ior_n_in, iow_n_in} = 3'h7;
        {addr_hi_in, tb_aen, dma_enable_in, dma_req_in, legacy_irq_in, ext_irq_event_in, last_tc} = 7'h00;
        {dma_sel_in, irq_sel_in, addr_in, ack_dly, data_in} = 19'h00000;
        repeat (12) @(negedge ref_clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge ref_clk_in);
        io_wr(3'h5, 1'b0, 8'h3C, 1'b0, 1'b0, 1'b1);
        io_wr(3'h2, 1'b1, 8'hC3, 1'b0, 1'b0, 1'b1);
        io_wr(3'h7, 1'b0, 8'h5A, 1'b1, 1'b0, 1'b0);
        io_wr(3'h6, 1'b1, 8'h99, 1'b0, 1'b1, 1'b0);
        io_rd(1'b0, 1'b1);
        io_rd(1'b1, 1'b0);
        s_irq();
        s_dma(2'h0, 1'b0);
        s_dma(2'h1, 1'b0);
        s_dma(2'h2, 1'b1);
        final_report();
    end
endmodule // isa_host_bus_port_tb_top
`default_nettype wire
